// file: hdl/qdac_link.sv
module qdac_link import qdac_pkg::*; (
    // Serial pins
    input wire logic serial_clk,
    input wire logic frame_sync_n,
    input wire logic serial_in,
    output logic serial_out,
    // Bus-domain side
    input wire logic [15:0] rb_word,
    output logic done_tgl,
    output qdac_frame_t frame_word
);
    logic [15:0] shift_r; // Input shift register
    logic [4:0] rise_cnt_r; // Rising edges this frame
    logic [4:0] fall_cnt_r; // Falling edges this frame
    logic tgl_r = 1'b0; // Commit event toggle

    assign done_tgl = tgl_r;

    // Rising edges counted; frame-sync high ends the frame
    always_ff @(posedge serial_clk or posedge frame_sync_n) begin
        if (frame_sync_n) begin
            rise_cnt_r <= '0;
        end else if (rise_cnt_r != FRAME_BITS) begin
            rise_cnt_r <= rise_cnt_r + 5'h01;
        end
    end

    // Capture, most significant bit first
    always_ff @(posedge serial_clk) begin
        if (!frame_sync_n && rise_cnt_r != FRAME_BITS) begin
            shift_r <= {shift_r[14:0], serial_in};
        end
    end

    // Readback bit launched on each rising edge
    always_ff @(posedge serial_clk or posedge frame_sync_n) begin
        if (frame_sync_n) begin
            serial_out <= 1'b0;
        end else if (rise_cnt_r != FRAME_BITS) begin
            serial_out <= rb_word[4'hf - rise_cnt_r[3:0]];
        end
    end

    // Falling edges counted for the commit point
    always_ff @(negedge serial_clk or posedge frame_sync_n) begin
        if (frame_sync_n) begin
            fall_cnt_r <= '0;
        end else if (fall_cnt_r != FRAME_BITS) begin
            fall_cnt_r <= fall_cnt_r + 5'h01;
        end
    end

    // Word held stable and toggle flipped at the sixteenth fall
    always_ff @(negedge serial_clk) begin
        if (!frame_sync_n && fall_cnt_r == LAST_FALL) begin
            frame_word <= shift_r;
            tgl_r <= ~tgl_r;
        end
    end
endmodule // qdac_link

// file: hdl/qdac_pkg.sv
// Behaviour
// - Clear pin acts on its falling edge
// - Load strobe ignored while clear held low
// - Clear zeroes all input and DAC registers
// - Frame opens on frame-sync low; rising-edge capture
// - Write commits at sixteenth falling serial edge
// - Early frame-sync rise discards partial write
// - Sixteen-bit input shift register, rising edges
// - DAC and control registers readable on serial_out
// - Readback launched rising edge, sampled falling
// - Load low copies new inputs to DACs together
// - Load tied low updates DAC on write
// - Overtemp flag low above die threshold
// - Range pin low selects high range
// - Reset: control 0x40, data registers zero
// - Control bits two to five power channels
// - Control bit six picks powerdown load
// - Powerdown keeps DAC register contents
package qdac_pkg;
    // Frame geometry
    localparam logic [4:0] FRAME_BITS = 5'h10;
    localparam logic [4:0] LAST_FALL = 5'h0f;
    // Frame address codes
    localparam logic [2:0] ADDR_CH_A = 3'h1;
    localparam logic [2:0] ADDR_ALL = 3'h5;
    localparam logic [2:0] ADDR_CTRL = 3'h7;
    // Control register
    localparam logic [7:0] CTRL_RST = 8'h40;
    localparam int CTRL_PWR_LSB = 2;
    localparam int CTRL_PDSEL_BIT = 6;
    // Bus register byte offsets
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_CTRL = 8'h04;
    localparam logic [7:0] OFS_CMD = 8'h08;
    localparam logic [7:0] OFS_FRAME = 8'h0c;
    localparam logic [7:0] OFS_DAC = 8'h10;
    localparam logic [7:0] OFS_INPUT = 8'h20;
    // Status and command bit positions
    localparam int ST_CLEAR_LOW = 0;
    localparam int ST_HOT = 1;
    localparam int ST_RANGE30 = 2;
    localparam int ST_NEW_LSB = 4;
    localparam int CMD_LOAD = 0;
    localparam int CMD_CLEAR = 1;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // One serial frame
    typedef struct packed {
        logic rd;
        logic [2:0] addr;
        logic [11:0] data;
    } qdac_frame_t;

    // What the analog section sees
    typedef struct packed {
        logic [3:0][11:0] code;
        logic [3:0] power_on;
        logic pd_ground;
        logic range_60v;
    } qdac_analog_t;
endpackage

// file: hdl/qdac_sync.sv
module qdac_sync import qdac_pkg::*; #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r; // First stage, read only by q

    // Two-flop level synchroniser
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_r <= RST;
            q <= RST;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule // qdac_sync

// file: hdl/qdac_top.sv
module qdac_top import qdac_pkg::*; (
    // Bus clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    // AXI4-Lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // AXI4-Lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Serial link
    input wire logic serial_clk,
    input wire logic frame_sync_n,
    input wire logic serial_in,
    output logic serial_out,
    // Control pins
    input wire logic async_clear_n,
    input wire logic load_update_n,
    input wire logic range_select_n,
    output logic overtemp_flag_n,
    // Analog section
    input wire logic die_over_temp,
    output qdac_analog_t analog
);
    // True when a frame address selects channel i
    function automatic logic chan_hit(input logic [2:0] a, input int i);
        chan_hit = (a == ADDR_ALL) || (a == ADDR_CH_A + 3'(i));
    endfunction

    // Pin synchronisers
    logic [3:0] pin_s; // Synced pins
    logic clear_s; // Clear pin, synced
    logic ld_s; // Load pin, synced
    logic rng_s; // Range pin, synced
    logic hot_s; // Detector, synced

    // Pins pass two flops before any logic
    qdac_sync #(.W(4), .RST(4'h7)) u_pin_sync (
        .clk(aclk),
        .rst_n(aresetn),
        .d({die_over_temp, range_select_n, load_update_n, async_clear_n}),
        .q(pin_s)
    );
    assign clear_s = pin_s[0];
    assign ld_s = pin_s[1];
    assign rng_s = pin_s[2];
    assign hot_s = pin_s[3];

    // Serial link in its own clock domain
    logic done_tgl; // Commit toggle, link domain
    logic tgl_s; // Same, synced
    qdac_frame_t link_word; // Held until next commit
    logic [15:0] rb_word_r; // Readback word to link

    qdac_link u_link (
        .serial_clk(serial_clk),
        .frame_sync_n(frame_sync_n),
        .serial_in(serial_in),
        .serial_out(serial_out),
        .rb_word(rb_word_r),
        .done_tgl(done_tgl),
        .frame_word(link_word)
    );

    qdac_sync #(.W(1), .RST(1'b0)) u_tgl_sync (
        .clk(aclk),
        .rst_n(aresetn),
        .d(done_tgl),
        .q(tgl_s)
    );

    // Commit event detection
    logic arm_r; // Toggle baseline taken
    logic seen_r; // Last toggle value seen
    logic frame_evt; // One frame arrived

    // The toggle has no reset, so the first cycle adopts it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arm_r <= 1'b0;
            seen_r <= 1'b0;
        end else begin
            arm_r <= 1'b1;
            seen_r <= tgl_s;
        end
    end
    assign frame_evt = arm_r && (tgl_s != seen_r);

    // Decoded frame events
    logic wr_evt; // Data or control write
    logic rd_evt; // Readback request
    assign wr_evt = frame_evt && !link_word.rd;
    assign rd_evt = frame_evt && link_word.rd;

    // Clear and load decode
    logic clear_d_r; // Clear pin, one cycle late
    logic soft_load; // Bus load pulse
    logic soft_clear; // Bus clear pulse
    logic clear_evt; // Zero all data registers
    logic copy_en; // Move new inputs to DACs

    // Edge detector on the synced clear pin
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clear_d_r <= 1'b1;
        end else begin
            clear_d_r <= clear_s;
        end
    end
    assign clear_evt = (clear_d_r && !clear_s) || soft_clear;
    // Load is a level: a pulse or a tie both copy
    assign copy_en = clear_s && !clear_evt && (!ld_s || soft_load);

    // Data registers
    logic [3:0][11:0] in_r; // Input registers
    logic [3:0][11:0] dac_r; // DAC registers
    logic [3:0] new_r; // Input not yet loaded
    logic [7:0] ctrl_r; // Control register

    // Input registers follow serial writes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            in_r <= '0;
        end else if (clear_evt) begin
            in_r <= '0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (wr_evt && chan_hit(link_word.addr, i)) begin
                    in_r[i] <= link_word.data;
                end
            end
        end
    end

    // New-data flags; a write in the copy cycle wins
    always_ff @(posedge aclk) begin
        if (!aresetn || clear_evt) begin
            new_r <= '0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (wr_evt && chan_hit(link_word.addr, i)) begin
                    new_r[i] <= 1'b1;
                end else if (copy_en) begin
                    new_r[i] <= 1'b0;
                end
            end
        end
    end

    // DAC registers load only channels with new data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dac_r <= '0;
        end else if (clear_evt) begin
            dac_r <= '0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (copy_en && new_r[i]) begin
                    dac_r[i] <= in_r[i];
                end
            end
        end
    end

    // Bus write strobes
    logic bus_wr; // Bus write performed
    logic [7:0] bus_wa; // Its address
    logic [31:0] bus_wd; // Its data
    logic [3:0] bus_ws; // Its strobes

    // Control register: serial write beats bus write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= CTRL_RST;
        end else if (wr_evt && link_word.addr == ADDR_CTRL) begin
            ctrl_r <= link_word.data[7:0];
        end else if (bus_wr && bus_wa == OFS_CTRL && bus_ws[0]) begin
            ctrl_r <= bus_wd[7:0];
        end
    end

    // Readback word; powerdown never touches dac_r
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rb_word_r <= '0;
        end else if (rd_evt) begin
            rb_word_r[15:12] <= {1'b1, link_word.addr};
            rb_word_r[11:0] <= '0;
            for (int i = 0; i < 4; i++) begin
                if (link_word.addr == ADDR_CH_A + 3'(i)) begin
                    rb_word_r[11:0] <= dac_r[i];
                end
            end
            if (link_word.addr == ADDR_CTRL) begin
                rb_word_r[11:0] <= {4'h0, ctrl_r};
            end
        end
    end

    // Analog outputs and alarm, all from flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            analog <= '0;
            overtemp_flag_n <= 1'b1;
        end else begin
            analog.code <= dac_r;
            analog.power_on <= ctrl_r[CTRL_PWR_LSB +: 4];
            analog.pd_ground <= ctrl_r[CTRL_PDSEL_BIT];
            analog.range_60v <= !rng_s;
            overtemp_flag_n <= !hot_s;
        end
    end

    // AXI write channel holding
    logic aw_got_r; // Address held
    logic w_got_r; // Data held
    logic [7:0] awaddr_r; // Held address
    logic [31:0] wdata_r; // Held data
    logic [3:0] wstrb_r; // Held strobes
    logic aw_take; // Address taken now
    logic w_take; // Data taken now

    assign awready = !aw_got_r && !bvalid;
    assign wready = !w_got_r && !bvalid;
    assign aw_take = awvalid && awready;
    assign w_take = wvalid && wready;
    assign bus_wr = (aw_got_r || aw_take) && (w_got_r || w_take);
    assign bus_wa = aw_got_r ? awaddr_r : awaddr;
    assign bus_wd = w_got_r ? wdata_r : wdata;
    assign bus_ws = w_got_r ? wstrb_r : wstrb;

    // Either channel may arrive first
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
        end else if (bus_wr) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
        end else begin
            if (aw_take) begin
                aw_got_r <= 1'b1;
                awaddr_r <= awaddr;
            end
            if (w_take) begin
                w_got_r <= 1'b1;
                wdata_r <= wdata;
                wstrb_r <= wstrb;
            end
        end
    end

    // Write response one cycle after both halves
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else if (bus_wr) begin
            bvalid <= 1'b1;
            bresp <= (bus_wa == OFS_CTRL || bus_wa == OFS_CMD) ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // Command pulses last one cycle only
    assign soft_load = bus_wr && bus_wa == OFS_CMD && bus_ws[0] && bus_wd[CMD_LOAD];
    assign soft_clear = bus_wr && bus_wa == OFS_CMD && bus_ws[0] && bus_wd[CMD_CLEAR];

    // Read mux; unmapped reads zero with an error
    logic [31:0] rd_mux; // Selected word
    logic rd_ok; // Address mapped
    always_comb begin
        rd_mux = '0;
        rd_ok = 1'b1;
        if (araddr == OFS_STATUS) begin
            rd_mux[ST_CLEAR_LOW] = !clear_s;
            rd_mux[ST_HOT] = hot_s;
            rd_mux[ST_RANGE30] = rng_s;
            rd_mux[ST_NEW_LSB +: 4] = new_r;
        end else if (araddr == OFS_CTRL) begin
            rd_mux[7:0] = ctrl_r;
        end else if (araddr == OFS_FRAME) begin
            rd_mux[15:0] = link_word;
        end else if (araddr[7:4] == OFS_DAC[7:4] && araddr[1:0] == 2'h0) begin
            rd_mux[11:0] = dac_r[araddr[3:2]];
        end else if (araddr[7:4] == OFS_INPUT[7:4] && araddr[1:0] == 2'h0) begin
            rd_mux[11:0] = in_r[araddr[3:2]];
        end else begin
            rd_ok = 1'b0;
        end
    end

    // Read data one cycle after the address
    assign arready = !rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata <= rd_mux;
            rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // Checks
    AST_CLEAR_ZERO: assert property (
        @(posedge aclk) disable iff (!aresetn)
        clear_evt |=> (dac_r == '0 && in_r == '0 && new_r == '0))
        else $error("clear left data registers nonzero");

    AST_LOAD_IGNORED: assert property (
        @(posedge aclk) disable iff (!aresetn)
        !clear_s |=> ($stable(dac_r) || dac_r == '0))
        else $error("DAC loaded while clear held low");

    AST_CTRL_RESET: assert property (
        @(posedge aclk)
        $rose(aresetn) |-> (ctrl_r == CTRL_RST && dac_r == '0))
        else $error("reset state wrong");

    AST_WRITE_LANDS: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (wr_evt && link_word.addr == ADDR_CH_A && !clear_evt)
            |=> in_r[0] == $past(link_word.data) && new_r[0])
        else $error("channel A write not committed");

    AST_TIED_LOW: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (!ld_s && clear_s && wr_evt && link_word.addr == ADDR_ALL && !clear_evt)
            ##1 (!ld_s && !clear_evt) |=> dac_r == {4{$past(link_word.data, 2)}})
        else $error("tied-low load did not update DACs");

    AST_HOLD_NO_LOAD: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (ld_s && !soft_load && !clear_evt) |=> $stable(dac_r))
        else $error("DAC changed without load");

    AST_OVERTEMP: assert property (
        @(posedge aclk) disable iff (!aresetn)
        hot_s [*2] |-> !overtemp_flag_n)
        else $error("overtemp flag not low");

    AST_POWER_BITS: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (wr_evt && link_word.addr == ADDR_CTRL)
            |-> ##2 analog.power_on == $past(link_word.data[5:2], 2))
        else $error("channel power not following control");

    AST_RANGE: assert property (
        @(posedge aclk) disable iff (!aresetn)
        $fell(rng_s) |=> analog.range_60v)
        else $error("range select not applied");

    AST_BRESP_HOLD: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (bvalid && !bready) |=> bvalid && $stable(bresp))
        else $error("write response dropped");
endmodule // qdac_top

// file: verification/qdac_host.sv
// Serial master on the far side of the link
module qdac_host (
    // Serial pins
    output logic serial_clk,
    output logic frame_sync_n,
    output logic serial_in,
    input wire logic serial_out
);
    timeunit 1ns;
    timeprecision 1ns;

    // Clock idles low and stands still between frames
    initial begin
        serial_clk = 1'b0;
        frame_sync_n = 1'b1;
        serial_in = 1'b0;
    end

    // One frame, MSB first; nb below 16 cuts the frame short
    task automatic xfer(input logic [15:0] w, input int nb, output logic [15:0] rb);
        rb = 16'h0000;
        frame_sync_n = 1'b0;
        #37;
        for (int i = 15; i > 15 - nb; i--) begin
            serial_in = w[i];
            #16 serial_clk = 1'b1;
            #32 serial_clk = 1'b0;
            rb[i] = serial_out;
            #16;
        end
        // Early rise aborts; data line flips so a stale bit is never trusted
        frame_sync_n = 1'b1;
        serial_in = ~serial_in;
        // Gap longer than the crossing needs
        #900;
    endtask
endmodule // qdac_host

// file: verification/testbench.sv
module testbench;
    import qdac_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    // Bus side stimulus
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rd;
    logic [3:0] wstrb;
    logic [1:0] rs;
    // Pins
    logic async_clear_n, load_update_n, range_select_n, die_over_temp;
    // Design outputs
    logic awready, wready, bvalid, arready, rvalid, serial_out, overtemp_flag_n;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic serial_clk, frame_sync_n, serial_in;
    qdac_analog_t analog;
    logic [15:0] rb;
    int num_errors, num_checks;

    qdac_top dut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
        .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
        .serial_clk, .frame_sync_n, .serial_in, .serial_out, .async_clear_n, .load_update_n,
        .range_select_n, .overtemp_flag_n, .die_over_temp, .analog);
    qdac_host host (.serial_clk, .frame_sync_n, .serial_in, .serial_out);

    // Bus clock, 100 ns
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    // Verdict and end of run
    task automatic stop_test();
        $display("Checks %0d, errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // Compare and count
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Bounded wait ran out
    task automatic hang();
        num_errors++;
        stop_test();
    endtask

    task automatic clks(input int n);
        repeat (n) @(posedge aclk);
    endtask

    // Address and data offered together, each dropped once taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge aclk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
            if (n > 50) hang();
        end
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge aclk);
            n++;
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
            if (n > 50) hang();
        end
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    // Read a register, expect data and OKAY
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        axi_rd(a, rd, rs);
        chk(rd, exp);
        chk(rs, RESP_OKAY);
    endtask

    // Low level long enough to pass the synchroniser
    task automatic pulse_load();
        @(posedge aclk);
        load_update_n <= 1'b0;
        clks(3);
        load_update_n <= 1'b1;
        clks(6);
    endtask

    task automatic t_reset();
        rd_chk(OFS_CTRL, 32'h40);
        rd_chk(OFS_DAC, 32'h0);
        chk(analog, {48'h0, 4'h0, 2'b10});
        // Unmapped and read-only places refuse
        axi_rd(8'h40, rd, rs);
        chk(rs, RESP_SLVERR);
        axi_wr(OFS_STATUS, 32'h1, rs);
        chk(rs, RESP_SLVERR);
    endtask

    // Two channels wait for one load, then move together
    task automatic t_write_load();
        host.xfer({1'b0, ADDR_CH_A, 12'habc}, 16, rb);
        host.xfer({1'b0, ADDR_CH_A + 3'h2, 12'h5c3}, 16, rb);
        rd_chk(OFS_INPUT, 32'habc);
        chk(analog.code[0], 12'h0);
        pulse_load();
        chk({analog.code[2], analog.code[0]}, 24'h5c3abc);
    endtask

    // Fifteen bits only: nothing may change
    task automatic t_abort();
        host.xfer({1'b0, ADDR_CH_A, 12'h123}, 15, rb);
        rd_chk(OFS_INPUT, 32'habc);
    endtask

    // Read frame, then two frames shifting values out
    task automatic t_readback();
        host.xfer({1'b1, ADDR_CH_A, 12'h0}, 16, rb);
        host.xfer({1'b1, ADDR_CTRL, 12'h0}, 16, rb);
        chk(rb, {1'b1, ADDR_CH_A, 12'habc});
        host.xfer({1'b0, 3'h6, 12'h0}, 16, rb);
        chk(rb, {1'b1, ADDR_CTRL, 12'h040});
    endtask

    // Load held low: write lands on the DAC at once
    task automatic t_tie_low();
        @(posedge aclk);
        load_update_n <= 1'b0;
        host.xfer({1'b0, ADDR_ALL, 12'h5a5}, 16, rb);
        chk(analog.code, {4{12'h5a5}});
        @(posedge aclk);
        load_update_n <= 1'b1;
    endtask

    // Bus load command, status flags and last frame word
    task automatic t_cmd();
        host.xfer({1'b0, ADDR_CH_A, 12'h321}, 16, rb);
        rd_chk(OFS_STATUS, 32'h14);
        rd_chk(OFS_FRAME, 32'h1321);
        axi_wr(OFS_CMD, 32'h1, rs);
        chk(rs, RESP_OKAY);
        rd_chk(OFS_DAC, 32'h321);
        rd_chk(OFS_DAC + 8'h04, 32'h5a5);
    endtask

    // Power bits, powerdown load, range and temperature pins
    task automatic t_ctrl();
        host.xfer({1'b0, ADDR_CTRL, 12'h03c}, 16, rb);
        chk({analog.power_on, analog.pd_ground}, 5'h1e);
        chk(analog.code[0], 12'h5a5);
        axi_wr(OFS_CTRL, 32'h40, rs);
        chk(rs, RESP_OKAY);
        clks(6);
        chk({analog.power_on, analog.pd_ground, analog.code[0]}, 17'h0_15a5);
        range_select_n <= 1'b0;
        die_over_temp <= 1'b1;
        clks(6);
        chk({analog.range_60v, overtemp_flag_n}, 2'b10);
        range_select_n <= 1'b1;
        die_over_temp <= 1'b0;
        clks(6);
        chk({analog.range_60v, overtemp_flag_n}, 2'b01);
    endtask

    // Clear zeroes all; load ignored while it stays low
    task automatic t_clear();
        @(posedge aclk);
        async_clear_n <= 1'b0;
        clks(6);
        chk(analog.code, 48'h0);
        rd_chk(OFS_INPUT, 32'h0);
        host.xfer({1'b0, ADDR_ALL, 12'h777}, 16, rb);
        rd_chk(OFS_INPUT + 8'h0c, 32'h777);
        pulse_load();
        chk(analog.code[3], 12'h0);
        async_clear_n <= 1'b1;
        clks(4);
        pulse_load();
        chk(analog.code, {4{12'h777}});
        // Bus clear command zeroes everything too
        axi_wr(OFS_CMD, 32'h2, rs);
        chk(rs, RESP_OKAY);
        clks(2);
        chk(analog.code, 48'h0);
        rd_chk(OFS_INPUT + 8'h0c, 32'h0);
    endtask

    // Main sequence
    initial begin
        num_errors = 0;
        num_checks = 0;
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        wstrb = 4'hf;
        async_clear_n = 1'b1;
        load_update_n = 1'b1;
        range_select_n = 1'b1;
        die_over_temp = 1'b0;
        clks(20);
        aresetn <= 1'b1;
        clks(5);
        t_reset();
        t_write_load();
        t_abort();
        t_readback();
        t_tie_low();
        t_ctrl();
        t_cmd();
        t_clear();
        stop_test();
    end
endmodule // testbench
